// ===== design/nhc_pkg.sv
// constants, types and step encoding for the nand host command controller
// assumes a 50 MHz clock and one nand device on an 8-bit shared i/o bus
`default_nettype none
package nhc_pkg;
	// timing, each figure in ns then the cycle count; the sync latency in cycles only
	localparam int CLK_PERIOD_NS = 20;
	localparam int STROBE_NS = 25;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WHR_NS = 60;
	localparam int WHR_CYC = (WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WB_NS = 100;
	localparam int WB_CYC = (WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_LAT = 3;
	// register byte offsets
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_CMD = 8'h04;
	localparam logic [7:0] ADR_STAT = 8'h08;
	localparam logic [7:0] ADR_DATA0 = 8'h0c;
	localparam logic [7:0] ADR_DATA1 = 8'h10;
	localparam logic [7:0] ADR_SRC_ROW = 8'h14;
	localparam logic [7:0] ADR_DST_ROW = 8'h18;
	// field positions and reset values
	localparam int CTRL_WPN_BIT = 0;
	localparam logic CTRL_WPN_RST = 1'b0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_REFUSED_BIT = 1;
	localparam int STAT_RDY_BIT = 2;
	localparam int STAT_INIT_BIT = 3;
	localparam int STAT_PFV_BIT = 4;
	localparam int STAT_SMODE_BIT = 5;
	localparam int SB_RDY_A = 5;
	localparam int SB_RDY_B = 6;
	localparam int ROW_DISTRICT_BIT = 6;
	localparam int ROW_W = 24;
	localparam logic [ROW_W-1:0] ROW_RST = 24'h000000;
	localparam int RBUF_N = 5;
	localparam int STEPS = 9;
	// nand command codes and address bytes
	localparam logic [7:0] NC_RESET = 8'hff;
	localparam logic [7:0] NC_STATUS = 8'h70;
	localparam logic [7:0] NC_ID = 8'h90;
	localparam logic [7:0] NC_ID_ADDR = 8'h00;
	localparam logic [7:0] NC_ECC_STATUS = 8'h7a;
	localparam logic [7:0] NC_READ = 8'h00;
	localparam logic [7:0] NC_CB_READ = 8'h35;
	localparam logic [7:0] NC_CB_IN = 8'h85;
	localparam logic [7:0] NC_PROG_GO = 8'h10;
	localparam logic [7:0] COL_ZERO = 8'h00;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0, OP_RESET = 3'h1, OP_STATUS = 3'h2, OP_ID = 3'h3,
		OP_ECC = 3'h4, OP_RESUME = 3'h5, OP_CB_READ = 3'h6, OP_CB_PROG = 3'h7
	} nhc_op_t;

	typedef enum logic [2:0] {
		K_CMD = 3'h0, K_ADDR = 3'h1, K_DLY = 3'h2, K_READ = 3'h3, K_WRB = 3'h4, K_END = 3'h5
	} nhc_kind_t;

	typedef struct packed {
		nhc_kind_t kind;
		logic [7:0] val;
	} nhc_step_t;

	typedef struct packed {
		logic ce_n;
		logic cle;
		logic ale;
		logic we_n;
		logic read_strobe_n;
		logic wp_n;
		logic io_oe;
		logic [7:0] io_o;
	} nhc_pins_t;
endpackage
`default_nettype wire

// ===== design/nhc_sync.sv
// three-stage input synchroniser with agreement filter
// assumes inputs are asynchronous pins; output changes when stages two and three agree
`default_nettype none
module nhc_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	generate
		if (W < 1) begin : g_chk
			$error("nhc_sync width must be at least one");
		end
	endgenerate

	// s1 feeds only s2, to keep metastability off any logic
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			q_o <= '0;
		end else begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				q_o <= s3_q;
			end
		end
	end
endmodule
`default_nettype wire

// ===== design/nhc_top.sv
// nand host command controller: reset, status, id, ecc status, read resume, copy-back
// assumes a classic wishbone master on the register side and one nand device on the pins
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`default_nettype none
module nhc_top #(
	parameter int STROBE = nhc_pkg::STROBE_CYC,
	parameter int WHR = nhc_pkg::WHR_CYC,
	parameter int TWB = nhc_pkg::WB_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output nhc_pkg::nhc_pins_t pins_o,
	input wire logic [7:0] io_i,
	input wire logic ready_busy_n_i
);
	import nhc_pkg::*;
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001, ST_NEXT = 5'b00010, ST_LOW = 5'b00100, ST_HIGH = 5'b01000, ST_WAIT = 5'b10000
	} nhc_state_t;
	if (STROBE < 1 || STROBE + SYNC_LAT > 255 || WHR < 1 || WHR > 255 || TWB < 1 || TWB > 255) begin : g_chk
		$error("nhc_top timing counts out of range");
	end
	nhc_state_t state_q;
	nhc_step_t step_q [STEPS];
	logic [3:0] idx_q;
	logic [7:0] cnt_q, io_q, io_s;
	logic [2:0] rd_idx_q;
	logic [7:0] rbuf_q [RBUF_N];
	logic cle_q, ale_q, we_n_q, re_n_q, oe_q, ce_n_q, wpn_q;
	logic [ROW_W-1:0] src_row_q, dst_row_q, cb_row_q;
	logic cb_valid_q, smode_q, init_q, refused_q, ack_q;
	nhc_op_t last_op_q, req_op;
	logic [31:0] dat_q;
	nhc_step_t cur;
	logic rb_s, bus_wr, start_req, bad, start_ok, busy, pf_valid;
	nhc_sync #(.W(9)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({ready_busy_n_i, io_i}),
		.q_o({rb_s, io_s})
	);
	// wishbone writes land on the edge where the master sees ack
	assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
	assign req_op = nhc_op_t'(wb_dat_i[2:0]);
	assign start_req = bus_wr && wb_adr_i == ADR_CMD && wb_sel_i[0] && req_op != OP_NONE;
	assign busy = state_q != ST_IDLE;
	assign cur = step_q[idx_q];
	// refusal: busy, init window, copy-back program without a valid source or across districts, resume outside status mode
	assign bad = busy
		| (!init_q & req_op != OP_RESET & req_op != OP_STATUS)
		| (req_op == OP_CB_PROG & (!cb_valid_q
			| dst_row_q[ROW_DISTRICT_BIT] != cb_row_q[ROW_DISTRICT_BIT]))
		| (req_op == OP_RESUME & !smode_q);
	assign start_ok = start_req & !bad;
	// pass/fail only trusted when the captured status byte says ready
	assign pf_valid = last_op_q == OP_STATUS & rbuf_q[0][SB_RDY_A] & rbuf_q[0][SB_RDY_B];
	// step list per operation; a fixed script keeps the pin sequencer generic
	function automatic nhc_step_t step_of(input nhc_op_t op, input logic [3:0] i, input logic [ROW_W-1:0] row);
		nhc_step_t s;
		s = '{kind: K_END, val: 8'h00};
		case (op)
			OP_RESET: begin
				if (i == 4'h0) s = '{kind: K_CMD, val: NC_RESET};
				else if (i == 4'h1) s = '{kind: K_WRB, val: 8'h00};
			end
			OP_STATUS: begin
				if (i == 4'h0) s = '{kind: K_CMD, val: NC_STATUS};
				else if (i == 4'h1) s = '{kind: K_DLY, val: 8'h00};
				else if (i == 4'h2) s = '{kind: K_READ, val: 8'h00};
			end
			OP_ID: begin
				if (i == 4'h0) s = '{kind: K_CMD, val: NC_ID};
				else if (i == 4'h1) s = '{kind: K_ADDR, val: NC_ID_ADDR};
				else if (i == 4'h2) s = '{kind: K_DLY, val: 8'h00};
				else if (i < 4'h8) s = '{kind: K_READ, val: 8'h00};
			end
			OP_ECC: begin
				if (i == 4'h0) s = '{kind: K_CMD, val: NC_ECC_STATUS};
				else if (i == 4'h1) s = '{kind: K_DLY, val: 8'h00};
				else if (i < 4'h6) s = '{kind: K_READ, val: 8'h00};
			end
			OP_RESUME: if (i == 4'h0) s = '{kind: K_CMD, val: NC_READ};
			OP_CB_READ, OP_CB_PROG: begin
				if (i == 4'h0) s = '{kind: K_CMD, val: (op == OP_CB_READ) ? NC_READ : NC_CB_IN};
				else if (i < 4'h3) s = '{kind: K_ADDR, val: COL_ZERO};
				else if (i == 4'h3) s = '{kind: K_ADDR, val: row[7:0]};
				else if (i == 4'h4) s = '{kind: K_ADDR, val: row[15:8]};
				else if (i == 4'h5) s = '{kind: K_ADDR, val: row[23:16]};
				else if (i == 4'h6) s = '{kind: K_CMD, val: (op == OP_CB_READ) ? NC_CB_READ : NC_PROG_GO};
				else if (i == 4'h7) s = '{kind: K_WRB, val: 8'h00};
			end
			default: s = '{kind: K_END, val: 8'h00};
		endcase
		return s;
	endfunction
	// script storage, one entry per step; it reloads only on an accepted start
	for (genvar gi = 0; gi < STEPS; gi++) begin : g_step
		always_ff @(posedge clk_i) begin
			if (rst_i) step_q[gi] <= '{kind: K_END, val: 8'h00};
			else if (start_ok) step_q[gi] <= step_of(req_op, 4'(gi), (req_op == OP_CB_READ) ? src_row_q : dst_row_q);
		end
	end
	// pin sequencer: strobe low phase, high phase, waits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			idx_q <= 4'h0;
			cnt_q <= 8'h00;
			rd_idx_q <= 3'h0;
			cle_q <= 1'b0;
			ale_q <= 1'b0;
			we_n_q <= 1'b1;
			re_n_q <= 1'b1;
			oe_q <= 1'b0;
			io_q <= 8'h00;
			ce_n_q <= 1'b1;
			rbuf_q <= '{default: 8'h00};
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start_ok) begin
						idx_q <= 4'h0;
						rd_idx_q <= 3'h0;
						ce_n_q <= 1'b0;
						state_q <= ST_NEXT;
					end
				end
				ST_NEXT: begin
					case (cur.kind)
						K_CMD, K_ADDR: begin
							cle_q <= cur.kind == K_CMD;
							ale_q <= cur.kind == K_ADDR;
							oe_q <= 1'b1;
							io_q <= cur.val;
							we_n_q <= 1'b0;
							cnt_q <= 8'(STROBE - 1);
							state_q <= ST_LOW;
						end
						K_READ: begin
							re_n_q <= 1'b0;
							cnt_q <= 8'(STROBE + SYNC_LAT - 1); // pin data needs the sync latency
							state_q <= ST_LOW;
						end
						K_DLY: begin
							cnt_q <= 8'(WHR - 1);
							state_q <= ST_WAIT;
						end
						K_WRB: begin
							cnt_q <= 8'(TWB - 1); // busy may not show before twb
							state_q <= ST_WAIT;
						end
						default: begin
							ce_n_q <= 1'b1;
							state_q <= ST_IDLE;
						end
					endcase
				end
				ST_LOW: begin
					if (cnt_q == 8'h00) begin
						we_n_q <= 1'b1;
						if (!re_n_q) begin
							rbuf_q[rd_idx_q] <= io_s; // bytes stored in arrival order
							rd_idx_q <= rd_idx_q + 3'h1;
						end
						re_n_q <= 1'b1;
						cnt_q <= 8'(STROBE - 1);
						state_q <= ST_HIGH;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				ST_HIGH: begin
					if (cnt_q == 8'h00) begin
						cle_q <= 1'b0;
						ale_q <= 1'b0;
						oe_q <= 1'b0;
						idx_q <= idx_q + 4'h1;
						state_q <= ST_NEXT;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				ST_WAIT: begin
					if (cnt_q != 8'h00) begin
						cnt_q <= cnt_q - 8'h01;
					end else if (cur.kind != K_WRB || rb_s) begin
						idx_q <= idx_q + 4'h1;
						state_q <= ST_NEXT;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
	// operation bookkeeping: status mode, copy-back source, init tracking
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			smode_q <= 1'b0;
			cb_valid_q <= 1'b0;
			cb_row_q <= ROW_RST;
			last_op_q <= OP_NONE;
			init_q <= 1'b0;
		end else begin
			if (rb_s && !busy) init_q <= 1'b1; // device left its power-on busy
			if (start_ok) begin
				last_op_q <= req_op;
				smode_q <= req_op == OP_STATUS;
				if (req_op == OP_CB_READ) begin
					cb_valid_q <= 1'b1;
					cb_row_q <= src_row_q;
				end else if (req_op == OP_RESET || req_op == OP_CB_PROG) begin
					cb_valid_q <= 1'b0;
				end
			end
		end
	end
	// refused flag: write one clears, a new refusal in the same cycle wins
	always_ff @(posedge clk_i) begin
		if (rst_i) refused_q <= 1'b0;
		else if (start_req && bad) refused_q <= 1'b1;
		else if (bus_wr && wb_adr_i == ADR_STAT && wb_sel_i[0] && wb_dat_i[STAT_REFUSED_BIT]) refused_q <= 1'b0;
	end
	// software registers with byte lanes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wpn_q <= CTRL_WPN_RST;
			src_row_q <= ROW_RST;
			dst_row_q <= ROW_RST;
		end else if (bus_wr) begin
			if (wb_adr_i == ADR_CTRL && wb_sel_i[0]) wpn_q <= wb_dat_i[CTRL_WPN_BIT];
			for (int b = 0; b < 3; b++) begin
				if (wb_sel_i[b] && wb_adr_i == ADR_SRC_ROW) src_row_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
				if (wb_sel_i[b] && wb_adr_i == ADR_DST_ROW) dst_row_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
			end
		end
	end
	// ack one cycle after the request, dropped the cycle after; unmapped reads zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h00000000;
		end else begin
			ack_q <= wb_cyc_i & wb_stb_i & !ack_q;
			case (wb_adr_i)
				ADR_CTRL: dat_q <= {31'h00000000, wpn_q};
				ADR_STAT: dat_q <= {16'h0000, rbuf_q[0], 2'b00, smode_q, pf_valid, init_q, rb_s, refused_q, busy};
				ADR_DATA0: dat_q <= {rbuf_q[3], rbuf_q[2], rbuf_q[1], rbuf_q[0]};
				ADR_DATA1: dat_q <= {24'h000000, rbuf_q[4]};
				ADR_SRC_ROW: dat_q <= {8'h00, src_row_q};
				ADR_DST_ROW: dat_q <= {8'h00, dst_row_q};
				default: dat_q <= 32'h00000000;
			endcase
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign pins_o = '{ce_n: ce_n_q, cle: cle_q, ale: ale_q, we_n: we_n_q, read_strobe_n: re_n_q,
		wp_n: wpn_q, io_oe: oe_q, io_o: io_q};
	AST_COPYBACK_DISTRICT: assert property (@(posedge clk_i) disable iff (rst_i)
		(start_req && req_op == OP_CB_PROG && !busy && dst_row_q[ROW_DISTRICT_BIT] != cb_row_q[ROW_DISTRICT_BIT])
		|=> (state_q == ST_IDLE && refused_q)) else $error("copy-back across districts was started");
	AST_INIT_ONLY_RESET_STATUS: assert property (@(posedge clk_i) disable iff (rst_i)
		(start_req && !init_q && req_op == OP_ID) |=> (state_q == ST_IDLE && ce_n_q))
		else $error("id read started during initialization");
	AST_RESUME_NEEDS_STATUS: assert property (@(posedge clk_i) disable iff (rst_i)
		(start_req && !busy && req_op == OP_RESUME && !smode_q) |=> refused_q)
		else $error("resume accepted outside status mode");
	AST_STROBE_LOW_WIDTH: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(re_n_q) |=> !re_n_q [*4])
		else $error("read strobe low phase too short");
	AST_READ_BUS_RELEASED: assert property (@(posedge clk_i) disable iff (rst_i)
		!re_n_q |-> (!oe_q && !ce_n_q && we_n_q)) else $error("bus driven during read strobe");
	AST_WE_QUALIFIED: assert property (@(posedge clk_i) disable iff (rst_i)
		!we_n_q |-> (oe_q && (cle_q ^ ale_q) && !ce_n_q))
		else $error("write strobe without latch or data");
	AST_ID_FIVE_READS: assert property (@(posedge clk_i) disable iff (rst_i)
		($rose(ce_n_q) && last_op_q == OP_ID) |-> rd_idx_q == 3'h5) // ce_n rises as the sequencer goes idle
		else $error("id read did not take five bytes");
	AST_ECC_FOUR_READS: assert property (@(posedge clk_i) disable iff (rst_i)
		($rose(ce_n_q) && last_op_q == OP_ECC) |-> $past(rd_idx_q) == 3'h4)
		else $error("ecc status read did not take four bytes");
	AST_SMODE_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i)
		(smode_q && !start_ok) |=> smode_q) else $error("status mode lost without a command");
	AST_ACK_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

// ===== sim/nhc_nand_model.sv
// behavioural nand device facing the host controller pins
// assumes the bench resolves the shared io wire and pulls ready/busy up
`default_nettype none
module nhc_nand_model #(
	parameter logic [7:0] MAKER_ID = 8'h5c, // arbitrary value
	parameter logic [7:0] DEVICE_ID = 8'h3b, // arbitrary value
	parameter int INIT_NS = 4000,
	parameter int READ_NS = 1000,
	parameter int PROG_NS = 1500,
	parameter int RST_NS = 300
) (
	input wire nhc_pkg::nhc_pins_t pins_i,
	input wire logic [7:0] io_i,
	output logic [7:0] io_o,
	output logic io_oe_o,
	output logic busy_o
);
	timeunit 1ns;
	timeprecision 100ps;
	import nhc_pkg::*;
	localparam int M_IDLE = 0;
	localparam int M_STAT = 1;
	localparam int M_ID = 2;
	localparam int M_ECC = 3;
	localparam int M_READ = 4;
	int mode = M_IDLE;
	int idx = 0;
	int busy_ns = INIT_NS; // busy from power-on until initialization ends
	logic fail_q = 1'b0;
	logic rew_q = 1'b0;
	// sector in high nibble, corrected count (at most 8, f = uncorrectable) low
	logic [7:0] ecc_q [4] = '{8'h00, 8'h11, 8'h28, 8'h3f};

	initial io_o = 8'h00;
	initial io_oe_o = 1'b0;
	assign busy_o = busy_ns > 0;
	// internal operations run down in 10 ns steps
	always #10 if (busy_ns > 0) busy_ns -= 10;

	// byte that the current mode puts out for one read strobe
	function automatic logic [7:0] out_byte();
		case (mode)
			M_STAT: return {pins_i.wp_n, !busy_o, !busy_o, 1'b0, rew_q, 2'b00, fail_q};
			M_ID: case (idx)
				0: return MAKER_ID;
				1: return DEVICE_ID;
				2: return 8'h90; // one chip, two levels
				3: return 8'h15; // 2 KB page, 128 KB block, x8
				default: return 8'hf6; // two districts, ecc on chip
			endcase
			M_ECC: return ecc_q[idx % 4];
			default: return 8'hff;
		endcase
	endfunction

	// commands latch on the rising write strobe while selected
	always @(posedge pins_i.we_n) begin
		if (!pins_i.ce_n && pins_i.cle) begin
			idx = 0;
			case (io_i)
				NC_RESET: begin // abort: any operation ends after a short discharge
					busy_ns = RST_NS;
					mode = M_IDLE;
					fail_q = 1'b0;
					rew_q = 1'b0;
				end
				NC_STATUS: mode = M_STAT; // stays until another command
				NC_ID: mode = M_ID;
				NC_ECC_STATUS: mode = M_ECC;
				NC_READ: mode = M_READ; // leaves status mode, output resumes
				NC_CB_READ: busy_ns = READ_NS;
				NC_PROG_GO: begin
					busy_ns = PROG_NS;
					fail_q = 1'b0; // the rewrite hint is a read result only
					rew_q = 1'b0;
				end
				default: ;
			endcase
		end
	end

	// data follows the falling read strobe; released after it rises
	always @(negedge pins_i.read_strobe_n) begin
		if (!pins_i.ce_n) begin
			#8;
			io_o = out_byte();
			io_oe_o = 1'b1;
		end
	end
	always @(posedge pins_i.read_strobe_n) begin
		#5;
		io_oe_o = 1'b0;
		if (mode == M_ID || mode == M_ECC) idx++; // one byte per strobe, in order
	end
endmodule
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the nand host command controller
// assumes the nand model beside it and the design's default timing parameters
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import nhc_pkg::*;
	localparam logic [7:0] MAKER = 8'h5c; // arbitrary value
	localparam logic [7:0] DEVICE = 8'h3b; // arbitrary value
	logic clk_i, rst_i, cyc, stb, we, ack, m_oe, m_busy, rb_n;
	logic [7:0] adr, m_io, io_last, io_w;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	nhc_pins_t pins;
	int errors = 0;
	int n_compared = 0;
	int cycles = 0;

	nhc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.pins_o(pins), .io_i(io_w), .ready_busy_n_i(rb_n));
	nhc_nand_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVICE)) u_nand (.pins_i(pins), .io_i(io_w),
		.io_o(m_io), .io_oe_o(m_oe), .busy_o(m_busy));

	// open-drain ready/busy with pull-up; an undriven io bus shows the inverse of its last value
	assign rb_n = m_busy ? 1'b0 : 1'b1;
	assign io_w = pins.io_oe ? pins.io_o : (m_oe ? m_io : ~io_last);
	always @(pins.io_oe, pins.io_o, m_oe, m_io) begin
		if (pins.io_oe) io_last = pins.io_o;
		else if (m_oe) io_last = m_io;
	end

	task automatic results();
		if (errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	// one classic wishbone cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	// polls the busy flag; a long wait is cut by the bench timeout
	task automatic wait_idle();
		do wb(1'b0, ADR_STAT, 32'h0); while (q[STAT_BUSY_BIT] !== 1'b0);
	endtask
	// orders one operation, checks the refusal flag, then clears it
	task automatic op(input logic [2:0] code, input logic refused);
		wb(1'b1, ADR_CMD, {29'h0, code});
		wb(1'b0, ADR_STAT, 32'h0);
		chk(32'(q[STAT_REFUSED_BIT]), 32'(refused));
		wb(1'b1, ADR_STAT, 32'h2);
	endtask
	// pass/fail is only read back once the operation has ended
	task automatic status(input logic [7:0] exp);
		op(3'h2, 1'b0);
		wait_idle();
		chk(32'(q[15:8]), 32'(exp));
	endtask

	task automatic t_power_on();
		chk(32'({pins.ce_n, pins.wp_n, pins.io_oe}), 32'h4);
		op(3'h3, 1'b1);
		status(8'h00);
		chk(32'(q[STAT_PFV_BIT]), 32'h0);
		do wb(1'b0, ADR_STAT, 32'h0); while (q[STAT_INIT_BIT] !== 1'b1);
		chk(32'(q[STAT_RDY_BIT]), 32'h1);
		wb(1'b0, ADR_CTRL, 32'h0);
		chk(q, 32'h0);
		wb(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
	endtask
	task automatic t_status();
		wb(1'b1, ADR_CTRL, 32'h1);
		status(8'he0);
		chk(32'(q[STAT_SMODE_BIT]), 32'h1);
		chk(32'(q[STAT_PFV_BIT]), 32'h1);
		wb(1'b1, ADR_CTRL, 32'h0);
		status(8'h60);
		wb(1'b1, ADR_CTRL, 32'h1);
	endtask
	task automatic t_id();
		op(3'h3, 1'b0);
		wait_idle();
		chk(32'(q[STAT_SMODE_BIT]), 32'h0);
		wb(1'b0, ADR_DATA0, 32'h0);
		chk(q, {8'h15, 8'h90, DEVICE, MAKER});
		wb(1'b0, ADR_DATA1, 32'h0);
		chk(q, 32'h000000f6);
	endtask
	task automatic t_copy();
		wb(1'b1, ADR_SRC_ROW, 32'h000040);
		u_nand.rew_q = 1'b1;
		op(3'h6, 1'b0);
		wait_idle();
		status(8'he8);
		op(3'h5, 1'b0);
		wait_idle();
		chk(32'(q[STAT_SMODE_BIT]), 32'h0);
		op(3'h5, 1'b1);
		op(3'h4, 1'b0);
		wait_idle();
		wb(1'b0, ADR_DATA0, 32'h0);
		chk(q, 32'h3f281100);
		wb(1'b1, ADR_DST_ROW, 32'h000000);
		op(3'h7, 1'b1);
		wb(1'b1, ADR_DST_ROW, 32'h0000c0);
		op(3'h7, 1'b0);
		op(3'h2, 1'b1);
		wait_idle();
		status(8'he0);
	endtask
	task automatic t_reset();
		u_nand.fail_q = 1'b1;
		op(3'h6, 1'b0);
		wait_idle();
		status(8'he1);
		op(3'h1, 1'b0);
		wait_idle();
		op(3'h7, 1'b1);
		status(8'he0);
	endtask

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	initial begin
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'hf;
		wdat = 32'h0;
		io_last = 8'h00;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_power_on();
		t_status();
		t_id();
		t_copy();
		t_reset();
		results();
	end
	// a hang counts as a mismatch
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			errors++;
			results();
		end
	end
endmodule
`default_nettype wire
